// [hw/twc_field_check.v]
// Purpose: validity check of one hour/minute/second triple
// Assumes: fields are unsigned words
// Notes:   purely combinational
`timescale 1ns/100ps
`include "twc_regs.vh"
module twc_field_check (
  // fields
  input  wire [15:0] hour,
  input  wire [15:0] minute,
  input  wire [15:0] second,
  // result
  output wire        valid
);
  assign valid = (hour <= `TWC_HOUR_MAX) && (minute <= `TWC_MINSEC_MAX) &&
                 (second <= `TWC_MINSEC_MAX);
endmodule // twc_field_check

// [hw/twc_regs.vh]
// Purpose: constants for the time window comparator
// Assumes: APB register map at byte addresses, 32-bit data
// Notes:   offsets and codes are named here, logic uses the names
`ifndef TWC_REGS_VH
`define TWC_REGS_VH

`define TWC_OFF_CTRL      12'h000
`define TWC_OFF_STATUS    12'h004
`define TWC_OFF_IRQ_STAT  12'h008
`define TWC_OFF_IRQ_MASK  12'h00C
`define TWC_OFF_LO_BASE   12'h010
`define TWC_OFF_HI_BASE   12'h014
`define TWC_OFF_CUR_BASE  12'h018
`define TWC_OFF_RES_BASE  12'h01C
`define TWC_OFF_ERR_CODE  12'h020
`define TWC_OFF_MEM_ADDR  12'h024
`define TWC_OFF_MEM_DATA  12'h028

`define TWC_ERR_RANGE     16'h2003
`define TWC_HOUR_MAX      16'h0017
`define TWC_MINSEC_MAX    16'h003B

`define TWC_CTRL_EN_BIT   0
`define TWC_IRQ_ERR_BIT   0
`define TWC_IRQ_DONE_BIT  1

`define TWC_WORD_HOUR     2'h0
`define TWC_WORD_MIN      2'h1
`define TWC_WORD_SEC      2'h2
`define TWC_LAST_OFS      2'h2

`endif

// [hw/twc_top.v]
// Purpose: time window comparator with word memory, reached over APB
// Assumes: software loads words into the internal memory, sets bases, enables
// Notes:   one execution every cycle while enabled; results live in a bit array
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "twc_regs.vh"
module twc_top #(
  parameter WORDS  = 64,
  parameter AW     = 6,
  parameter RBITS  = 32,
  parameter RW     = 5
) (
  // clock and reset
  input  wire        mclk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // results and status
  output reg  [2:0]  result_bits_q,
  output reg         operation_error_flag,
  output reg         irq
);
  reg [15:0]      mem [0:WORDS-1];
  reg [RBITS-1:0] res_q;
  reg             en_q;
  reg [15:0]      lower_limit_base;
  reg [15:0]      upper_limit_base;
  reg [15:0]      cur_base_q;
  reg [15:0]      res_base_q;
  reg [15:0]      error_code_word;
  reg [15:0]      mem_addr_q;
  reg [1:0]       irq_stat_q;
  reg [1:0]       irq_mask_q;
  reg             err_ev;
  reg             done_ev;

  wire acc   = psel && penable;
  wire wr    = acc && pwrite;
  wire rd    = acc && !pwrite;

  // address range of each operand's last word
  wire lo_ok  = ({16'h0000, lower_limit_base} + `TWC_LAST_OFS) < WORDS;
  wire hi_ok  = ({16'h0000, upper_limit_base} + `TWC_LAST_OFS) < WORDS;
  wire cu_ok  = ({16'h0000, cur_base_q} + `TWC_LAST_OFS) < WORDS;
  wire rs_ok  = ({16'h0000, res_base_q} + `TWC_LAST_OFS) < RBITS;
  wire addr_ok = lo_ok && hi_ok && cu_ok && rs_ok;

  // safe indices; unused when address check fails
  wire [AW-1:0] lo_i = lo_ok ? lower_limit_base[AW-1:0] : {AW{1'b0}};
  wire [AW-1:0] hi_i = hi_ok ? upper_limit_base[AW-1:0] : {AW{1'b0}};
  wire [AW-1:0] cu_i = cu_ok ? cur_base_q[AW-1:0] : {AW{1'b0}};
  wire [RW-1:0] rs_i = rs_ok ? res_base_q[RW-1:0] : {RW{1'b0}};

  wire [15:0] lo_h = mem[lo_i];
  wire [15:0] lo_m = mem[lo_i + `TWC_WORD_MIN];
  wire [15:0] lo_s = mem[lo_i + `TWC_WORD_SEC];
  wire [15:0] hi_h = mem[hi_i];
  wire [15:0] hi_m = mem[hi_i + `TWC_WORD_MIN];
  wire [15:0] hi_s = mem[hi_i + `TWC_WORD_SEC];
  wire [15:0] cu_h = mem[cu_i];
  wire [15:0] cu_m = mem[cu_i + `TWC_WORD_MIN];
  wire [15:0] cu_s = mem[cu_i + `TWC_WORD_SEC];

  wire lo_v;
  wire hi_v;
  wire cu_v;
  twc_field_check u_lo (.hour(lo_h), .minute(lo_m), .second(lo_s), .valid(lo_v));
  twc_field_check u_hi (.hour(hi_h), .minute(hi_m), .second(hi_s), .valid(hi_v));
  twc_field_check u_cu (.hour(cu_h), .minute(cu_m), .second(cu_s), .valid(cu_v));
  wire val_ok = lo_v && hi_v && cu_v;

  // hour is most significant, so one concatenated compare orders times
  wire [47:0] lo_t = {lo_h, lo_m, lo_s};
  wire [47:0] hi_t = {hi_h, hi_m, hi_s};
  wire [47:0] cu_t = {cu_h, cu_m, cu_s};
  wire [47:0] up_t = (lo_t > hi_t) ? lo_t : hi_t;

  reg [2:0] cmp;
  always @* begin
    if (cu_t < lo_t && cu_t < up_t)
      cmp = 3'h1;
    else if (cu_t > lo_t && cu_t > up_t)
      cmp = 3'h4;
    else
      cmp = 3'h2;
  end

  wire run  = en_q;
  wire good = addr_ok && val_ok;

  // memory: writes from software only
  always @(posedge mclk) begin
    if (wr && paddr == `TWC_OFF_MEM_DATA && mem_addr_q < WORDS)
      mem[mem_addr_q[AW-1:0]] <= pwdata[15:0];
  end

  // execution
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      res_q                <= {RBITS{1'b0}};
      result_bits_q        <= 3'h0;
      operation_error_flag <= 1'b0;
      error_code_word      <= 16'h0000;
      err_ev               <= 1'b0;
      done_ev              <= 1'b0;
    end else begin
      err_ev  <= 1'b0;
      done_ev <= 1'b0;
      if (run) begin
        if (good) begin
          res_q[rs_i]                     <= cmp[0];
          res_q[rs_i + `TWC_WORD_MIN]     <= cmp[1];
          res_q[rs_i + `TWC_WORD_SEC]     <= cmp[2];
          result_bits_q                   <= cmp;
          done_ev                         <= 1'b1;
        end else begin
          operation_error_flag <= 1'b1;
          error_code_word      <= `TWC_ERR_RANGE;
          err_ev               <= 1'b1;
        end
      end
      // software clears the sticky flag; a new error wins
      if (wr && paddr == `TWC_OFF_STATUS && pwdata[0] && !(run && !good))
        operation_error_flag <= 1'b0;
    end
  end

  // registers, interrupts, apb
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      en_q             <= 1'b0;
      lower_limit_base <= 16'h0000;
      upper_limit_base <= 16'h0000;
      cur_base_q       <= 16'h0000;
      res_base_q       <= 16'h0000;
      mem_addr_q       <= 16'h0000;
      irq_stat_q       <= 2'h0;
      irq_mask_q       <= 2'h0;
      prdata           <= 32'h00000000;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      irq              <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (wr && pready) begin
        case (paddr)
          `TWC_OFF_CTRL:     en_q             <= pwdata[`TWC_CTRL_EN_BIT];
          `TWC_OFF_IRQ_MASK: irq_mask_q       <= pwdata[1:0];
          `TWC_OFF_LO_BASE:  lower_limit_base <= pwdata[15:0];
          `TWC_OFF_HI_BASE:  upper_limit_base <= pwdata[15:0];
          `TWC_OFF_CUR_BASE: cur_base_q       <= pwdata[15:0];
          `TWC_OFF_RES_BASE: res_base_q       <= pwdata[15:0];
          `TWC_OFF_MEM_ADDR: mem_addr_q       <= pwdata[15:0];
          `TWC_OFF_MEM_DATA: mem_addr_q       <= mem_addr_q + 16'h0001;
          default: ;
        endcase
      end
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `TWC_OFF_CTRL:     prdata <= {31'h0, en_q};
          `TWC_OFF_STATUS:   prdata <= {29'h0, result_bits_q[2:1], operation_error_flag};
          `TWC_OFF_IRQ_STAT: prdata <= {30'h0, irq_stat_q};
          `TWC_OFF_IRQ_MASK: prdata <= {30'h0, irq_mask_q};
          `TWC_OFF_LO_BASE:  prdata <= {16'h0, lower_limit_base};
          `TWC_OFF_HI_BASE:  prdata <= {16'h0, upper_limit_base};
          `TWC_OFF_CUR_BASE: prdata <= {16'h0, cur_base_q};
          `TWC_OFF_RES_BASE: prdata <= {16'h0, res_base_q};
          `TWC_OFF_ERR_CODE: prdata <= {16'h0, error_code_word};
          `TWC_OFF_MEM_ADDR: prdata <= {16'h0, mem_addr_q};
          `TWC_OFF_MEM_DATA: prdata <= res_q;
          default:           prdata <= 32'h00000000;
        endcase
      end
      if (psel && !penable) begin
        if (paddr > `TWC_OFF_MEM_DATA || paddr[1:0] != 2'h0)
          pslverr <= 1'b1;
      end
      // read clears, but a same-cycle event stays set
      irq_stat_q[`TWC_IRQ_ERR_BIT]  <= err_ev ||
        (irq_stat_q[`TWC_IRQ_ERR_BIT] && !(rd && pready && paddr == `TWC_OFF_IRQ_STAT));
      irq_stat_q[`TWC_IRQ_DONE_BIT] <= done_ev ||
        (irq_stat_q[`TWC_IRQ_DONE_BIT] && !(rd && pready && paddr == `TWC_OFF_IRQ_STAT));
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule // twc_top

// [testbench/time_window_comparator_test.sv]
// Purpose: directed APB test of the time window comparator
// Assumes: limits at words 0 and 3, current time at 6
// Notes:   expectations are worked out here
`timescale 1ns/100ps
module time_window_comparator_test;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, rerr, operation_error_flag, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0]  result_bits_q, ex, idx;
  logic [47:0] lo, hi, cur, u;
  int          fails, cmp_count, i;
  twc_top u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .result_bits_q(result_bits_q),
    .operation_error_flag(operation_error_flag), .irq(irq));
  twc_time_src u_src (.idx(idx), .lo(lo), .hi(hi), .cur(cur));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #80000;
    fails++;
    give_verdict;
  end
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    // no cycle limit here: a slave that never answers is caught by the watchdog
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", rdat, e);
  endtask
  task run;
    apb(1'b1, 12'h000, 32'h1);
    repeat (3) @(posedge mclk);
    apb(1'b1, 12'h000, 32'h0);
    repeat (2) @(posedge mclk);
  endtask
  task load(input logic [2:0] c);
    logic [143:0] w;
    idx <= c;
    @(posedge mclk);
    w = {lo, hi, cur};
    apb(1'b1, 12'h024, 32'h0);
    for (int k = 0; k < 9; k++) apb(1'b1, 12'h028, {16'h0, w[143-16*k -: 16]});
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, idx} = '0;
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b1, 12'h014, 32'h3);
    apb(1'b1, 12'h018, 32'h6);
    apb(1'b1, 12'h00C, 32'h3);
    rd(12'h020, 32'h0);
    for (i = 0; i < 6; i++) begin
      load(i[2:0]);
      u = (lo > hi) ? lo : hi;
      ex = (cur < lo && cur < u) ? 3'h1 : (cur > lo && cur > u) ? 3'h4 : 3'h2;
      run;
      chk("result", result_bits_q, ex);
      rd(12'h004, {29'h0, ex[2:1], 1'b0});
      rd(12'h028, {29'h0, ex});
    end
    load(3'h0);
    repeat (4) @(posedge mclk);
    chk("held", result_bits_q, 3'h2);
    rd(12'h008, 32'h2);
    load(3'h6);
    run;
    chk("flag", operation_error_flag, 1'b1);
    chk("kept", result_bits_q, 3'h2);
    rd(12'h020, 32'h2003);
    chk("irq", irq, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk("irq_stat", rdat[0], 1'b1);
    apb(1'b1, 12'h004, 32'h1);
    rd(12'h004, 32'h2);
    load(3'h1);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 12'h00C, i ? 32'h0 : 32'h3);
      apb(1'b1, i ? 12'h01C : 12'h018, i ? 32'h1E : 32'h3E);
      run;
      chk("flag", operation_error_flag, 1'b1);
      chk("irq", irq, i == 0);
      rd(12'h020, 32'h2003);
      apb(1'b1, i ? 12'h01C : 12'h018, i ? 32'h0 : 32'h6);
      apb(1'b1, 12'h004, 32'h1);
      apb(1'b0, 12'h008, 32'h0);
    end
    rd(12'h008, 32'h0);
    chk("irq_off", irq, 1'b0);
    rd(12'h02C, 32'h0);
    chk("pslverr", rerr, 1'b1);
    give_verdict;
  end
endmodule // time_window_comparator_test

// [testbench/twc_checker.sv]
// Purpose: port checks for the time window comparator
// Assumes: one clock, async high reset
// Notes:   enable is mirrored from CTRL writes
`timescale 1ns/100ps
module twc_checker (
  // clock, reset, apb
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // results
  input wire logic [2:0]  result_bits_q,
  input wire logic        operation_error_flag,
  input wire logic        irq
);
  logic en_q;
  wire  acc_w = psel && penable && pready && pwrite;
  always_ff @(posedge mclk or posedge rst)
    if (rst) en_q <= 1'b0;
    else if (acc_w && paddr == 12'h000) en_q <= pwdata[0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_onehot; $onehot0(result_bits_q); endproperty
  a_onehot: assert property (p_onehot) else $error("result not one-hot");
  property p_answer; psel && !penable |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no access answer");
  property p_access; pready |-> psel && penable; endproperty
  a_access: assert property (p_access) else $error("ready outside access");
  property p_resp; pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h028); endproperty
  a_resp: assert property (p_resp) else $error("wrong error response");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_sticky; operation_error_flag && !(acc_w && paddr == 12'h004 && pwdata[0]) |=> operation_error_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("error flag lost");
  property p_hold; !en_q [*2] |=> $stable(result_bits_q); endproperty
  a_hold: assert property (p_hold) else $error("result moved while off");
  property p_rise; $rose(operation_error_flag) |-> $past(en_q) || $past(en_q, 2); endproperty
  a_rise: assert property (p_rise) else $error("error without execution");
  c_below: cover property (result_bits_q == 3'h1);
  c_above: cover property (result_bits_q == 3'h4);
  c_err: cover property ($rose(operation_error_flag));
endmodule // twc_checker
bind twc_top twc_checker u_chk (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .result_bits_q(result_bits_q), .operation_error_flag(operation_error_flag), .irq(irq));

// [testbench/twc_time_src.sv]
// Purpose: controller program model handing out time triples
// Assumes: each time is hour, minute, second
// Notes:   cases 3 and 4 swap the limits on purpose
`timescale 1ns/100ps
module twc_time_src (
  // case select
  input  wire logic [2:0]  idx,
  // times as hour, minute, second words
  output logic      [47:0] lo,
  output logic      [47:0] hi,
  output logic      [47:0] cur
);
  always_comb
    case (idx)
      3'h0: {lo, hi, cur} = {48'h0008_0000_0000, 48'h0011_0000_0000, 48'h0007_003B_003B};
      3'h1: {lo, hi, cur} = {48'h0008_0000_0000, 48'h0011_0000_0000, 48'h0008_0000_0000};
      3'h2: {lo, hi, cur} = {48'h0008_0000_0000, 48'h0011_0000_0000, 48'h0011_0000_0001};
      3'h3: {lo, hi, cur} = {48'h000C_001E_0000, 48'h000A_0000_0000, 48'h000B_0000_0000};
      3'h4: {lo, hi, cur} = {48'h000C_001E_0000, 48'h000A_0000_0000, 48'h000C_001E_0001};
      3'h5: {lo, hi, cur} = {48'h000A_003B_003B, 48'h0017_003B_003B, 48'h000B_0000_0000};
      default: {lo, hi, cur} = {48'h0, 48'h0, 48'h0018_0000_0000};
    endcase
endmodule // twc_time_src
